// *** link_status_pkg.sv ***
`default_nettype none
package link_status_pkg;
	// Register geometry
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 5;
	localparam logic [ADDR_W-1:0] LINK_STATUS_WORD_ADDR = 5'h01;
	localparam logic [WORD_W-1:0] LINK_STATUS_WORD_RESET = 16'h7809;
	// Bit positions
	localparam int unsigned BIT_T4 = 15;
	localparam int unsigned BIT_CAP_HI = 14;
	localparam int unsigned BIT_CAP_LO = 11;
	localparam int unsigned BIT_RSV_HI = 10;
	localparam int unsigned BIT_RSV_LO = 7;
	localparam int unsigned BIT_PRE = 6;
	localparam int unsigned BIT_ANC = 5;
	localparam int unsigned BIT_RF = 4;
	localparam int unsigned BIT_ANA = 3;
	localparam int unsigned BIT_LINK = 2;
	localparam int unsigned BIT_JAB = 1;
	localparam int unsigned BIT_EXT = 0;
	// Field reset values
	localparam logic [3:0] CAP_RESET = 4'hf;
	localparam logic [3:0] RSV_RESET = 4'h0;
	localparam logic PRE_RESET = 1'h0;
endpackage
`default_nettype wire

// *** link_status_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_status_props
(
	input wire logic        clk_in,          // Clock
	input wire logic        rst_b_in,        // Reset, low
	input wire logic        rd_strobe_in,    // Read pulse
	input wire logic        wr_strobe_in,    // Write pulse
	input wire logic        override_en_in,  // Override
	input wire logic        aneg_en_in,      // Negotiation on
	input wire logic        link_ok_in,      // Link ok
	input wire logic        remote_fault_in, // Fault
	input wire logic        jabber_in,       // Jabber
	input wire logic [4:0]  reg_addr_in,     // Address
	input wire logic [15:0] rd_data_out      // Read data
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire h = rd_strobe_in && reg_addr_in == 5'h01;
	wire [15:0] q = rd_data_out;
	property p_fix; h |=> {q[15], q[3], q[0]} == 3'b011; endproperty
	a_fix: assert property (p_fix) else $error("fix");
	property p_rsv; h |=> q[10:7] == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_pre; h |=> !q[6]; endproperty
	a_pre: assert property (p_pre) else $error("pre");
	property p_anc; !aneg_en_in ##1 h && !aneg_en_in |=> !q[5]; endproperty
	a_anc: assert property (p_anc) else $error("anc");
	property p_jab; jabber_in ##1 !h ##1 h |=> q[1]; endproperty
	a_jab: assert property (p_jab) else $error("jab");
	property p_rf; remote_fault_in ##1 !h ##1 h |=> q[4]; endproperty
	a_rf: assert property (p_rf) else $error("rf");
	property p_lnk; !link_ok_in ##1 !h ##1 h |=> !q[2]; endproperty
	a_lnk: assert property (p_lnk) else $error("lnk");
	property p_clr; h && !jabber_in ##1 !jabber_in ##1 h |=> !q[1];
	endproperty
	a_clr: assert property (p_clr) else $error("clr");
	c_wr: cover property (wr_strobe_in && override_en_in);
	c_rd: cover property (h ##2 h);
	c_ln: cover property (!link_ok_in ##2 h);
endmodule
bind phy_link_status_register link_status_props u_props(
	.clk_in(clk_in),
	.rst_b_in(rst_b_in),
	.rd_strobe_in(rd_strobe_in),
	.wr_strobe_in(wr_strobe_in),
	.override_en_in(override_en_in),
	.aneg_en_in(aneg_en_in),
	.link_ok_in(link_ok_in),
	.remote_fault_in(remote_fault_in),
	.jabber_in(jabber_in),
	.reg_addr_in(reg_addr_in),
	.rd_data_out(rd_data_out)
);
`default_nettype wire

// *** phy_link_status_register.sv ***
// Operation
// - Sixteen-bit status word over management interface
// - Reset loads default value into every bit
// - Bit 15 always reads zero
// - Bits 14..11 capabilities, reset one, override-writable
// - Override-writable bits change only with override enabled
// - Reserved bits 10..7 read zero
// - Bit 6 preamble suppression ability, reset zero
// - Bit 5 latching-high negotiation complete
// - Bit 4 latching-high remote fault
// - Bits 3 and 0 always read one
// - Bit 2 latching-low link valid
// - Bit 1 latching-high jabber, cleared by read
// - Remote fault latch cleared by read
// - Completion flag zero while negotiation disabled
`timescale 1ns/1ps
`default_nettype none
module phy_link_status_register
(
	input wire logic                                clk_in,          // Clock
	input wire logic                                rst_b_in,        // Reset
	input wire logic [link_status_pkg::ADDR_W-1:0] reg_addr_in,     // Address
	input wire logic                                rd_strobe_in,    // Read
	input wire logic                                wr_strobe_in,    // Write
	input wire logic [link_status_pkg::WORD_W-1:0] wr_data_in,      // Data in
	input wire logic                                override_en_in,  // Unlock
	input wire logic                                aneg_en_in,      // Neg on
	input wire logic                                aneg_done_in,    // Neg done
	input wire logic                                remote_fault_in, // Fault
	input wire logic                                link_ok_in,      // Link ok
	input wire logic                                jabber_in,       // Jabber
	output logic     [link_status_pkg::WORD_W-1:0] rd_data_out      // Data out
);
	// Field positions and reset values
	import link_status_pkg::*;

	// Capability group state
	logic [3:0]        cap_r;       // Speed and duplex abilities
	logic [3:0]        cap_nxt;     // Next abilities
	logic [3:0]        rsv_r;       // Reserved bits, kept but hidden
	logic [3:0]        rsv_nxt;     // Next reserved bits
	logic              pre_r;       // Preamble suppression ability
	logic              pre_nxt;     // Next ability, never changes

	// Event latch group state
	logic              anc_r;       // Latched negotiation complete
	logic              anc_nxt;     // Next completion latch
	logic              rf_r;        // Latched remote fault
	logic              rf_nxt;      // Next fault latch
	logic              link_r;      // Latched-low link valid
	logic              link_nxt;    // Next link latch
	logic              jab_r;       // Latched jabber
	logic              jab_nxt;     // Next jabber latch

	// Read port state
	logic [WORD_W-1:0] rd_data_nxt; // Next read snapshot

	// Decoded requests and derived sources
	logic              hit_rd;      // Read aimed at this word
	logic              hit_wr;      // Write aimed at this word
	logic              cfg_wr;      // Write that may change bits
	logic              anc_src;     // Completion, gated by enable
	logic [WORD_W-1:0] word;        // Word as the manager sees it

	// True when the address selects this word
	// Shared by the read and write decode
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
		addr_hit = (addr == LINK_STATUS_WORD_ADDR);
	endfunction

	// Latching-high bit: an event sets it, a read clears it
	// The event wins when both fall in one cycle, so an
	// event seen during the read is never lost
	function automatic logic latch_high(
		input logic cur,        // Present latch value
		input logic src,        // Live event source
		input logic rd          // Read of this word
	);
		latch_high = src | (cur & ~rd);
	endfunction

	// Request decode and gated sources
	always_comb
	begin
		// Address match on each strobe
		hit_rd = rd_strobe_in & addr_hit(reg_addr_in);
		hit_wr = wr_strobe_in & addr_hit(reg_addr_in);
		cfg_wr = hit_wr & override_en_in;
		anc_src = aneg_en_in & aneg_done_in;
	end

	// Assembles the status word from the stored fields
	always_comb
	begin
		word = '0;
		word[BIT_T4] = 1'h0;
		// Capability bits as stored
		word[BIT_CAP_HI:BIT_CAP_LO] = cap_r;
		word[BIT_RSV_HI:BIT_RSV_LO] = '0;
		// Ability flag as stored
		word[BIT_PRE] = pre_r;
		word[BIT_ANC] = anc_r & aneg_en_in;
		// Latched fault
		word[BIT_RF] = rf_r;
		word[BIT_ANA] = 1'h1;
		// Latched-low link state
		word[BIT_LINK] = link_r;
		// Latched jabber
		word[BIT_JAB] = jab_r;
		word[BIT_EXT] = 1'h1;
	end

	// Next values of the capability group
	always_comb
	begin
		// Hold by default
		cap_nxt = cap_r;
		rsv_nxt = rsv_r;
		pre_nxt = pre_r;
		if (cfg_wr)
		begin
			cap_nxt = wr_data_in[BIT_CAP_HI:BIT_CAP_LO];
			// Reserved bits kept, never shown
			rsv_nxt = wr_data_in[BIT_RSV_HI:BIT_RSV_LO];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			// Abilities advertised, reserved clear
			cap_r <= CAP_RESET;
			rsv_r <= RSV_RESET;
			pre_r <= PRE_RESET;
		end
		else
		begin
			// Plain registering of next values
			cap_r <= cap_nxt;
			rsv_r <= rsv_nxt;
			pre_r <= pre_nxt;
		end
	end

	// Next values of the event latches
	always_comb
	begin
		anc_nxt = latch_high(anc_r, anc_src, hit_rd) & aneg_en_in;
		rf_nxt = latch_high(rf_r, remote_fault_in, hit_rd);
		jab_nxt = latch_high(jab_r, jabber_in, hit_rd);
		link_nxt = link_ok_in & (link_r | hit_rd);
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			// Latches start from the word's defaults
			anc_r <= LINK_STATUS_WORD_RESET[BIT_ANC];
			rf_r <= LINK_STATUS_WORD_RESET[BIT_RF];
			link_r <= LINK_STATUS_WORD_RESET[BIT_LINK];
			jab_r <= LINK_STATUS_WORD_RESET[BIT_JAB];
		end
		else
		begin
			// Plain registering of next values
			anc_r <= anc_nxt;
			rf_r <= rf_nxt;
			link_r <= link_nxt;
			jab_r <= jab_nxt;
		end
	end

	// Next read snapshot
	always_comb
	begin
		// Snapshot before the read clears latches
		if (hit_rd)
			rd_data_nxt = word;
		// No read: hold the last answer
		else
			rd_data_nxt = rd_data_out;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			// Output shows the default word
			rd_data_out <= LINK_STATUS_WORD_RESET;
		end
		else
		begin
			// Plain registering of next value
			rd_data_out <= rd_data_nxt;
		end
	end
endmodule
`default_nettype wire

// *** phy_link_status_register_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module phy_link_status_register_tb;
	logic clk_in = 0, rst_b_in = 0, override_en_in = 0, aneg_en_in = 1;
	logic aneg_done_in = 0, remote_fault_in = 0, link_ok_in = 1;
	logic jabber_in = 0, rd_strobe_in, wr_strobe_in;
	logic [4:0] reg_addr_in;
	logic [15:0] wr_data_in, rd_data_out;
	int err_total = 0, cmp_count = 0;
	initial forever #12.5 clk_in = ~clk_in;
	sta_model u_sta(.clk_in(clk_in), .rd_out(rd_strobe_in),
		.wr_out(wr_strobe_in), .a_out(reg_addr_in), .d_out(wr_data_in));
	phy_link_status_register u_dut(
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.reg_addr_in(reg_addr_in),
		.rd_strobe_in(rd_strobe_in),
		.wr_strobe_in(wr_strobe_in),
		.wr_data_in(wr_data_in),
		.override_en_in(override_en_in),
		.aneg_en_in(aneg_en_in),
		.aneg_done_in(aneg_done_in),
		.remote_fault_in(remote_fault_in),
		.link_ok_in(link_ok_in),
		.jabber_in(jabber_in),
		.rd_data_out(rd_data_out)
	);
	task automatic give_verdict;
		$display("errors %0d checks %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read the word and compare
	task automatic r(input logic [15:0] e);
		u_sta.acc(1'h0, 5'h01, 16'h0000);
		#1 cmp_count++;
		if (rd_data_out !== e)
		begin
			err_total++;
			$display("CHECK FAILED rd_data_out expected %h seen %h",
				e, rd_data_out);
		end
	endtask
	initial
	begin
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1;
		r(16'h7809);
		r(16'h780d);
		@(posedge clk_in) {jabber_in, remote_fault_in} <= 2'b11;
		@(posedge clk_in) {jabber_in, remote_fault_in} <= 2'b00;
		r(16'h781f);
		r(16'h780d);
		@(posedge clk_in) aneg_done_in <= 1;
		r(16'h782d);
		@(posedge clk_in) aneg_en_in <= 0;
		r(16'h780d);
		@(posedge clk_in) link_ok_in <= 0;
		@(posedge clk_in) link_ok_in <= 1;
		r(16'h7809);
		u_sta.acc(1'h1, 5'h01, 16'h0000);
		r(16'h780d);
		@(posedge clk_in) override_en_in <= 1;
		u_sta.acc(1'h1, 5'h01, 16'h8040);
		r(16'h000d);
		// Reset in mid-run restores the defaults
		@(posedge clk_in) rst_b_in <= 0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1;
		u_sta.acc(1'h1, 5'h02, 16'h0000);
		r(16'h7809);
		give_verdict;
	end
	initial
	begin
		#100000;
		err_total++;
		give_verdict;
	end
endmodule
`default_nettype wire

// *** sta_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sta_model
(
	input  wire logic        clk_in, // Clock
	output logic             rd_out, // Read pulse
	output logic             wr_out, // Write pulse
	output logic [4:0]       a_out,  // Address
	output logic [15:0]      d_out   // Write data
);
	// Bus idle at time zero
	initial {rd_out, wr_out, a_out, d_out} = '0;
	// One access, strobe held for one cycle
	task automatic acc(
		input logic        w, // Write when high
		input logic [4:0]  a, // Address
		input logic [15:0] d  // Write data
	);
		@(posedge clk_in);
		{rd_out, wr_out, a_out} <= {!w, w, a};
		d_out <= d & 16'hf87f;
		@(posedge clk_in);
		// Released data shows its inverse
		{rd_out, wr_out, d_out} <= {2'h0, ~d_out};
	endtask
endmodule
`default_nettype wire
